// [include/cfp_map.svh]
// Register map, field positions and unprogrammed values of the configuration fuse bank.
// Assumes a classic Wishbone slave with 32-bit data and one register per aligned word.
`ifndef CFP_MAP_SVH
`define CFP_MAP_SVH

// Byte offsets are not all multiples of four, so they serve directly as word indices.
`define CFP_IDX_DEBUG_ISA_STACK 24'h300006
`define CFP_IDX_BLOCK_CODE 24'h300008
`define CFP_IDX_BOOT_EEPROM_CODE 24'h300009
`define CFP_IDX_BLOCK_WRITE 24'h30000a
// Control and status registers of the shadow logic.
`define CFP_IDX_CONTROL 24'h300100
`define CFP_IDX_STATUS 24'h300101
`define CFP_IDX_WIDTH 24

// Field positions in the debug, instruction set and stack byte.
`define CFP_BIT_DEBUG_DIS 7
`define CFP_BIT_EXT_ISA 6
`define CFP_BIT_SINGLE_SUPPLY 2
`define CFP_BIT_STKRST 0
// Field positions in the boot and data EEPROM byte.
`define CFP_BIT_EEPROM 7
`define CFP_BIT_BOOT 6
// Implemented bit masks; every other bit reads as zero.
`define CFP_MASK_DEBUG_ISA_STACK 8'hc5
`define CFP_MASK_BLOCK 8'h0f
`define CFP_MASK_BOOT_EEPROM 8'hc0
// Unprogrammed values.
`define CFP_UNPROG_DEBUG_ISA_STACK 8'h85
`define CFP_UNPROG_BLOCK 8'h0f
`define CFP_UNPROG_BOOT_EEPROM 8'hc0
// Control register bits.
`define CFP_CTRL_PROG_MODE 0
`define CFP_CTRL_ERASE 1
`define CFP_CTRL_RELOAD 2
// Number of protected program blocks.
`define CFP_NUM_BLOCKS 4

`endif

// [include/cfp_pkg.sv]
// Types shared by the configuration fuse bank modules.
// Assumes the map header is included wherever offsets are needed.
package cfp_pkg;

    // Raw fuse bytes as held in the nonvolatile bank.
    typedef struct packed {
        logic [7:0] debugIsaStack;
        logic [7:0] blockCode;
        logic [7:0] bootEepromCode;
        logic [7:0] blockWrite;
    } cfp_fuses_t;

    // Decoded settings applied to the rest of the core.
    typedef struct packed {
        logic debuggerEnable;
        logic sharedPinsGpio;
        logic extendedIsaEnable;
        logic singleSupplyProgEnable;
        logic stackFaultResetEnable;
        logic [3:0] codeGuardBlock;
        logic codeGuardBoot;
        logic codeGuardEeprom;
        logic [3:0] writeGuardBlock;
    } cfp_settings_t;

    // Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [23:0] adr;
        logic [31:0] dat;
    } cfp_wb_req_t;

endpackage

// [design/cfp_decode.sv]
// Decoder from latched fuse bytes to active-high protection and mode settings.
// Assumes the bytes are stable between resets; output is registered.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_map.svh"

module cfp_decode
    import cfp_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire cfp_fuses_t fuses, // Latched fuse bytes.
    output cfp_settings_t settings // Decoded settings.
);

    typedef struct packed {
        cfp_settings_t settings;
    } cfp_dec_state_t;

    cfp_dec_state_t state;
    cfp_dec_state_t next_state;

    // Decode each field; a cleared fuse means protection on.
    always_comb
    begin
        next_state = state;
        // [RL1] Debugger off, pins free.
        // [RL2] Debugger on, pins reserved.
        next_state.settings.debuggerEnable = ~fuses.debugIsaStack[`CFP_BIT_DEBUG_DIS];
        next_state.settings.sharedPinsGpio = fuses.debugIsaStack[`CFP_BIT_DEBUG_DIS];
        // [RL3] Extension and indexing on.
        // [RL4] Legacy mode otherwise.
        next_state.settings.extendedIsaEnable = fuses.debugIsaStack[`CFP_BIT_EXT_ISA];
        // [RL5] Single-supply programming select.
        next_state.settings.singleSupplyProgEnable = fuses.debugIsaStack[`CFP_BIT_SINGLE_SUPPLY];
        // [RL6] Stack fault reset on.
        // [RL7] No reset when clear.
        next_state.settings.stackFaultResetEnable = fuses.debugIsaStack[`CFP_BIT_STKRST];
        // [RL10] Boot block guard.
        next_state.settings.codeGuardBoot = ~fuses.bootEepromCode[`CFP_BIT_BOOT];
        // [RL11] EEPROM code guard.
        next_state.settings.codeGuardEeprom = ~fuses.bootEepromCode[`CFP_BIT_EEPROM];
        for (int i = 0; i < `CFP_NUM_BLOCKS; i++)
        begin
            // [RL8] [RL9] Block code guards.
            next_state.settings.codeGuardBlock[i] = ~fuses.blockCode[i];
            // [RL12] [RL13] Block write guards.
            next_state.settings.writeGuardBlock[i] = ~fuses.blockWrite[i];
        end
    end

    // Reset leaves every protection on until the first decode.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '{settings: '{codeGuardBlock: 4'hf, writeGuardBlock: 4'hf,
                codeGuardBoot: 1'b1, codeGuardEeprom: 1'b1, default: 1'b0}};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign settings = state.settings;

endmodule
`default_nettype wire

// [design/cfp_fuse_cell.sv]
// One byte of clearable fuse storage, masked to its implemented bits.
// Assumes the owner issues clear and erase strobes only in programming mode.
`timescale 1ns/1ps
`default_nettype none

module cfp_fuse_cell
(
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [7:0] implMask, // Implemented bit mask.
    input wire logic [7:0] unprogValue, // Erased value of the byte.
    input wire logic clearEn, // Apply a clear with the data below.
    input wire logic [7:0] clearData, // Bits written as zero are cleared.
    input wire logic eraseEn, // Return the byte to its erased value.
    output logic [7:0] value // Stored byte, unimplemented bits zero.
);

    typedef struct packed {
        logic [7:0] bits;
        logic loaded;
    } cfp_cell_state_t;

    cfp_cell_state_t state;
    cfp_cell_state_t next_state;

    // Clearing only lowers bits, so a clear can never lift a protection; only erase raises them.
    always_comb
    begin
        next_state = state;
        if (!state.loaded || eraseEn)
        begin
            next_state.bits = unprogValue & implMask;
            next_state.loaded = 1'b1;
        end
        else if (clearEn)
        begin
            // [RL15] Clear-only update.
            next_state.bits = state.bits & clearData & implMask;
        end
    end

    // Storage survives the system reset in a real bank; here the first edge loads erased values.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // [RL14] Unimplemented bits read zero.
    assign value = state.bits & implMask;

endmodule
`default_nettype wire

// [design/cfp_config_bank.sv]
// Configuration fuse bank with a classic Wishbone register port.
// Assumes one clock, synchronous bus inputs and a master that holds requests until ack.
//
// Functional notes
// [RL1] Debug field one: debugger off, both shared pins are general I/O.
// [RL2] Debug field zero: debugger on, both shared pins reserved for debug.
// [RL3] Extended field one: instruction extension and indexed addressing on.
// [RL4] Extended field zero: extension and indexing off, legacy mode.
// [RL5] Single-supply programming on when one, off when zero.
// [RL6] Stack field one: stack full or underflow causes reset.
// [RL7] Stack field zero: no reset on stack full or underflow.
// [RL8] Blocks 0 and 1 code-protected when their bit is zero.
// [RL9] Blocks 2 and 3 code-protected when their bit is zero.
// [RL10] Boot block code-protected when bit 6 is zero.
// [RL11] Data EEPROM code-protected when bit 7 is zero.
// [RL12] Blocks 0 and 1 write-protected when their bit is zero.
// [RL13] Blocks 2 and 3 write-protected when their bit is zero.
// [RL14] Unimplemented bits read as zero.
// [RL15] Protection bits readable, clear-only, erased value one.
// [RL16] Programmer keeps block 2 and 3 bits set on small parts.
// [RL17] Fields latched at reset and applied until the next reset; the code also relatches them on a control write with the reload bit.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_map.svh"

module cfp_config_bank
    import cfp_pkg::*;
(
    input wire logic clk_sys, // System clock, 200 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [23:0] wb_adr_i, // Wishbone word index.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    input wire logic stackFull, // Hardware return stack is full.
    input wire logic stackUnderflow, // Hardware return stack underflowed.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    output logic wb_err_o, // Wishbone error for unmapped index.
    output logic debuggerEnable, // Background debugger active.
    output logic sharedPinsGpio, // Shared port pins a and b free as I/O.
    output logic extendedIsaEnable, // Instruction extension and indexing on.
    output logic singleSupplyProgEnable, // Single-supply programming on.
    output logic stackFaultReset, // Reset request from a stack fault.
    output logic [3:0] codeGuardBlock, // Code protection per program block.
    output logic codeGuardBoot, // Boot block code protection.
    output logic codeGuardEeprom, // Data EEPROM code protection.
    output logic [3:0] writeGuardBlock // Write protection per program block.
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------

    typedef struct packed {
        cfp_fuses_t applied;
        logic latchPending;
        logic progMode;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic stackReset;
        logic cellsLoaded;
    } cfp_bank_state_t;

    cfp_bank_state_t state;
    cfp_bank_state_t next_state;

    cfp_wb_req_t req;
    cfp_fuses_t stored;
    cfp_settings_t decoded;
    logic writeHit;
    logic [3:0] clearEn;
    logic eraseEn;
    logic [7:0] wrByte;
    logic [31:0] readWord;
    logic mapped;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
        adr: wb_adr_i, dat: wb_dat_i};

    // -------------------------------------------------------------------
    // Fuse storage
    // -------------------------------------------------------------------

    // A write takes effect only in the cycle the ack is raised.
    assign writeHit = req.cyc && req.stb && req.we && !state.ack && !state.err && req.sel[0];
    assign wrByte = req.dat[7:0];
    assign eraseEn = writeHit && (req.adr == `CFP_IDX_CONTROL) && req.dat[`CFP_CTRL_ERASE]
        && state.progMode;

    // Programming of the fuses is only honoured in programming mode.
    always_comb
    begin
        clearEn = '0;
        if (writeHit && state.progMode)
        begin
            clearEn[0] = (req.adr == `CFP_IDX_DEBUG_ISA_STACK);
            clearEn[1] = (req.adr == `CFP_IDX_BLOCK_CODE);
            clearEn[2] = (req.adr == `CFP_IDX_BOOT_EEPROM_CODE);
            clearEn[3] = (req.adr == `CFP_IDX_BLOCK_WRITE);
        end
    end

    // The mode byte is clear-only like the others, so its bits are set again through erase only.
    cfp_fuse_cell u_cell_debug
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .implMask(`CFP_MASK_DEBUG_ISA_STACK),
        .unprogValue(`CFP_UNPROG_DEBUG_ISA_STACK),
        .clearEn(clearEn[0]),
        .clearData(wrByte),
        .eraseEn(eraseEn),
        .value(stored.debugIsaStack)
    );

    cfp_fuse_cell u_cell_block_code
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .implMask(`CFP_MASK_BLOCK),
        .unprogValue(`CFP_UNPROG_BLOCK),
        .clearEn(clearEn[1]),
        .clearData(wrByte),
        .eraseEn(eraseEn),
        .value(stored.blockCode)
    );

    cfp_fuse_cell u_cell_boot_eeprom
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .implMask(`CFP_MASK_BOOT_EEPROM),
        .unprogValue(`CFP_UNPROG_BOOT_EEPROM),
        .clearEn(clearEn[2]),
        .clearData(wrByte),
        .eraseEn(eraseEn),
        .value(stored.bootEepromCode)
    );

    cfp_fuse_cell u_cell_block_write
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .implMask(`CFP_MASK_BLOCK),
        .unprogValue(`CFP_UNPROG_BLOCK),
        .clearEn(clearEn[3]),
        .clearData(wrByte),
        .eraseEn(eraseEn),
        .value(stored.blockWrite)
    );

    // -------------------------------------------------------------------
    // Decode of applied settings
    // -------------------------------------------------------------------

    cfp_decode u_decode
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .fuses(state.applied),
        .settings(decoded)
    );

    // -------------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------------

    // Reads show the stored bytes, so a programmer can verify before the next reset.
    always_comb
    begin
        readWord = '0;
        mapped = 1'b1;
        unique case (req.adr)
            // [RL15] Fields readable back.
            `CFP_IDX_DEBUG_ISA_STACK: readWord[7:0] = stored.debugIsaStack;
            `CFP_IDX_BLOCK_CODE: readWord[7:0] = stored.blockCode;
            `CFP_IDX_BOOT_EEPROM_CODE: readWord[7:0] = stored.bootEepromCode;
            `CFP_IDX_BLOCK_WRITE: readWord[7:0] = stored.blockWrite;
            `CFP_IDX_CONTROL: readWord[`CFP_CTRL_PROG_MODE] = state.progMode;
            `CFP_IDX_STATUS: readWord[7:0] = {7'h00, state.latchPending};
            default: mapped = 1'b0;
        endcase
    end

    // -------------------------------------------------------------------
    // Bus, latch and stack reset logic
    // -------------------------------------------------------------------

    // Single-cycle answer: ack or err one cycle after the request, dropped the next cycle.
    always_comb
    begin
        next_state = state;
        next_state.ack = 1'b0;
        next_state.err = 1'b0;
        if (req.cyc && req.stb && !state.ack && !state.err)
        begin
            next_state.ack = mapped;
            next_state.err = !mapped;
            next_state.rdata = (mapped && !req.we) ? readWord : '0;
            if (writeHit && req.adr == `CFP_IDX_CONTROL)
            begin
                next_state.progMode = req.dat[`CFP_CTRL_PROG_MODE];
                // A pending latch survives a control write, so the reset latch is never lost.
                next_state.latchPending = req.dat[`CFP_CTRL_RELOAD] || state.latchPending;
            end
        end
        // [RL17] Latch after reset and after a reload request.
        // The cells hold zero until their first edge, so the latch waits for them.
        next_state.cellsLoaded = 1'b1;
        if (state.latchPending && state.cellsLoaded
            && !(writeHit && req.adr == `CFP_IDX_CONTROL))
        begin
            next_state.applied = stored;
            next_state.latchPending = 1'b0;
        end
        // [RL6] Reset on stack fault.
        // [RL7] Gated by the field.
        next_state.stackReset = decoded.stackFaultResetEnable && (stackFull || stackUnderflow);
    end

    // Reset arms the latch; it fires one edge after the cells load their erased values.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '{applied: '{debugIsaStack: `CFP_UNPROG_DEBUG_ISA_STACK,
                blockCode: `CFP_UNPROG_BLOCK, bootEepromCode: `CFP_UNPROG_BOOT_EEPROM,
                blockWrite: `CFP_UNPROG_BLOCK}, latchPending: 1'b1, default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------

    assign wb_dat_o = state.rdata;
    assign wb_ack_o = state.ack;
    assign wb_err_o = state.err;
    assign debuggerEnable = decoded.debuggerEnable;
    assign sharedPinsGpio = decoded.sharedPinsGpio;
    assign extendedIsaEnable = decoded.extendedIsaEnable;
    assign singleSupplyProgEnable = decoded.singleSupplyProgEnable;
    assign stackFaultReset = state.stackReset;
    assign codeGuardBlock = decoded.codeGuardBlock;
    assign codeGuardBoot = decoded.codeGuardBoot;
    assign codeGuardEeprom = decoded.codeGuardEeprom;
    assign writeGuardBlock = decoded.writeGuardBlock;

endmodule
`default_nettype wire

// [tb/cfp_programmer_model.sv]
// Programmer model: a classic Wishbone master that clears and reads fuse bytes.
// Assumes one clock; the bench's timeout bounds every wait for an answer.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_map.svh"

module cfp_programmer_model
#(
    parameter bit SMALL_PART = 1'h0
)
(
    input wire logic clk_sys, // System clock.
    output logic cyc, // Bus cycle.
    output logic stb, // Bus strobe.
    output logic we, // Write enable.
    output logic [3:0] sel, // Byte selects.
    output logic [23:0] adr, // Register index.
    output logic [31:0] datW, // Write data.
    input wire logic ack, // Acknowledge.
    input wire logic err, // Error answer.
    input wire logic [31:0] datR // Read data.
);
    // ---------------------------------------------
    // Idle bus
    // ---------------------------------------------
    initial
    begin
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        sel = 4'h0;
        adr = 24'h0;
        datW = 32'h0;
    end

    // ---------------------------------------------
    // One transfer
    // ---------------------------------------------
    // Released lines show the inverse, so a slave that samples late sees garbage.
    task automatic xfer(input logic w, input logic [23:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic e);
        logic [7:0] b;
        b = d;
        if (SMALL_PART && (a == `CFP_IDX_BLOCK_CODE || a == `CFP_IDX_BLOCK_WRITE))
            b = b | 8'h0c;
        @(posedge clk_sys);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        sel <= 4'h1;
        adr <= a;
        datW <= {24'h0, b};
        // The answer is sampled at a rising edge, and the request is released at that edge.
        do
            @(posedge clk_sys);
        while (!(ack || err));
        q = datR;
        e = err;
        cyc <= 1'h0;
        stb <= 1'h0;
        adr <= ~a;
        datW <= ~{24'h0, b};
    endtask
endmodule
`default_nettype wire

// [tb/cfp_config_bank_assertions.sv]
// Checker for the fuse bank: bus answers, readback form and applied settings.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_map.svh"

module cfp_config_bank_assertions
(
    input wire logic clk_sys, // Clock.
    input wire logic rst, // Reset.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic wb_we_i, // Write.
    input wire logic [3:0] wb_sel_i, // Selects.
    input wire logic [23:0] wb_adr_i, // Index.
    input wire logic [31:0] wb_dat_i, // Write data.
    input wire logic stackFull, // Stack full.
    input wire logic stackUnderflow, // Stack underflow.
    input wire logic [31:0] wb_dat_o, // Read data.
    input wire logic wb_ack_o, // Ack.
    input wire logic wb_err_o, // Error.
    input wire logic debuggerEnable, // Debugger on.
    input wire logic sharedPinsGpio, // Pins free.
    input wire logic extendedIsaEnable, // Extension on.
    input wire logic singleSupplyProgEnable, // Single supply on.
    input wire logic stackFaultReset, // Stack reset.
    input wire logic [3:0] codeGuardBlock, // Code guards.
    input wire logic codeGuardBoot, // Boot guard.
    input wire logic codeGuardEeprom, // EEPROM guard.
    input wire logic [3:0] writeGuardBlock // Write guards.
);
    logic [2:0] sinceRst;
    logic [2:0] next_sinceRst;
    logic inMap;

    // Edges since reset, saturating; settings need three edges to settle.
    always_comb
        next_sinceRst = (sinceRst == 3'h7) ? sinceRst : sinceRst + 3'h1;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            sinceRst <= 3'h0;
        else
            sinceRst <= next_sinceRst;
    // Mapped indices.
    assign inMap = wb_adr_i inside {`CFP_IDX_DEBUG_ISA_STACK, `CFP_IDX_BLOCK_CODE,
        `CFP_IDX_BOOT_EEPROM_CODE, `CFP_IDX_BLOCK_WRITE, `CFP_IDX_CONTROL, `CFP_IDX_STATUS};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence reqTaken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence oneAnswer;
        (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence

    req_answer_a: assert property (reqTaken |=> oneAnswer)
        else $error("bus request not answered by a single pulse");
    err_unmapped_a: assert property (reqTaken and !inMap |=> wb_err_o)
        else $error("unmapped index not refused");
    ack_mapped_a: assert property (reqTaken and inMap |=> wb_ack_o)
        else $error("mapped index not acknowledged");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("unused read bits not zero");
    pins_exclusive_a: assert property (
        sinceRst == 3'h7 |-> debuggerEnable != sharedPinsGpio)
        else $error("debugger and free pins disagree");
    stack_cause_a: assert property (
        sinceRst > 3'h1 && stackFaultReset |-> $past(stackFull || stackUnderflow))
        else $error("stack reset without a stack fault");
    isa_legacy_a: assert property (sinceRst == 3'h7 |-> !extendedIsaEnable)
        else $error("extension on with field erased");
    guard_hold_a: assert property (
        sinceRst == 3'h7 && ($changed(codeGuardBlock) || $changed(writeGuardBlock))
        |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
        else $error("guards changed without reload");
endmodule

bind cfp_config_bank cfp_config_bank_assertions cfp_config_bank_assertions_inst (.clk_sys, .rst,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .stackFull, .stackUnderflow,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .debuggerEnable, .sharedPinsGpio, .extendedIsaEnable,
    .singleSupplyProgEnable, .stackFaultReset, .codeGuardBlock, .codeGuardBoot,
    .codeGuardEeprom, .writeGuardBlock);
`default_nettype wire

// [tb/tb_top.sv]
// Testbench: programs fuse bytes over Wishbone and checks readback and applied settings.
// Assumes the programmer model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cfp_map.svh"

module tb_top;
    logic clk_sys, rst, stackFull, stackUnderflow, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0] wb_sel_i, codeGuardBlock, writeGuardBlock;
    logic [23:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic wb_ack_o, wb_err_o, debuggerEnable, sharedPinsGpio, extendedIsaEnable, e;
    logic singleSupplyProgEnable, stackFaultReset, codeGuardBoot, codeGuardEeprom;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    cfp_config_bank cfp_config_bank_inst (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_sel_i, .wb_adr_i, .wb_dat_i, .stackFull, .stackUnderflow, .wb_dat_o, .wb_ack_o,
        .wb_err_o, .debuggerEnable, .sharedPinsGpio, .extendedIsaEnable, .singleSupplyProgEnable,
        .stackFaultReset, .codeGuardBlock, .codeGuardBoot, .codeGuardEeprom, .writeGuardBlock);
    cfp_programmer_model cfp_programmer_model_inst (.clk_sys(clk_sys), .cyc(wb_cyc_i),
        .stb(wb_stb_i), .we(wb_we_i), .sel(wb_sel_i), .adr(wb_adr_i), .datW(wb_dat_i),
        .ack(wb_ack_o), .err(wb_err_o), .datR(wb_dat_o));

    // ---------------------------------------------
    // Clock and timeout
    // ---------------------------------------------
    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // The run needs well under a thousand cycles; a hang ends it as a failure.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        cfp_programmer_model_inst.xfer(1'h1, a, d, q, e);
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] exp);
        cfp_programmer_model_inst.xfer(1'h0, a, 8'h0, q, e);
        check(q, exp);
    endtask
    // Settings packed as debug, pins, extension, supply, code, boot, eeprom, write.
    function automatic logic [31:0] outs();
        return {18'h0, debuggerEnable, sharedPinsGpio, extendedIsaEnable, singleSupplyProgEnable,
            codeGuardBlock, codeGuardBoot, codeGuardEeprom, writeGuardBlock};
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial
    begin
        rst = 1'h1;
        stackFull = 1'h0;
        stackUnderflow = 1'h0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        rd(`CFP_IDX_DEBUG_ISA_STACK, 32'h85);
        rd(`CFP_IDX_BLOCK_CODE, 32'h0f);
        rd(`CFP_IDX_BOOT_EEPROM_CODE, 32'hc0);
        rd(`CFP_IDX_BLOCK_WRITE, 32'h0f);
        check(outs(), 32'h1400);
        cfp_programmer_model_inst.xfer(1'h0, 24'h300007, 8'h0, q, e);
        check({31'h0, e}, 32'h1);
        $display("test erased state done");
        stackFull <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, stackFaultReset}, 32'h1);
        stackFull <= 1'h0;
        stackUnderflow <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, stackFaultReset}, 32'h1);
        stackUnderflow <= 1'h0;
        $display("test stack reset done");
        // Clears outside program mode are acknowledged but must not stick.
        wr(`CFP_IDX_BLOCK_CODE, 8'h00);
        rd(`CFP_IDX_BLOCK_CODE, 32'h0f);
        wr(`CFP_IDX_CONTROL, 8'h01);
        wr(`CFP_IDX_DEBUG_ISA_STACK, 8'hff);
        rd(`CFP_IDX_DEBUG_ISA_STACK, 32'h85);
        wr(`CFP_IDX_DEBUG_ISA_STACK, 8'h04);
        wr(`CFP_IDX_BLOCK_CODE, 8'h0a);
        wr(`CFP_IDX_BOOT_EEPROM_CODE, 8'h80);
        wr(`CFP_IDX_BLOCK_WRITE, 8'h05);
        rd(`CFP_IDX_DEBUG_ISA_STACK, 32'h04);
        rd(`CFP_IDX_BLOCK_CODE, 32'h0a);
        rd(`CFP_IDX_BOOT_EEPROM_CODE, 32'h80);
        rd(`CFP_IDX_BLOCK_WRITE, 32'h05);
        check(outs(), 32'h1400);
        wr(`CFP_IDX_CONTROL, 8'h05);
        repeat (3) @(posedge clk_sys);
        check(outs(), 32'h256a);
        $display("test program and reload done");
        stackUnderflow <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check({31'h0, stackFaultReset}, 32'h0);
        stackUnderflow <= 1'h0;
        wr(`CFP_IDX_CONTROL, 8'h03);
        rd(`CFP_IDX_BLOCK_CODE, 32'h0f);
        rd(`CFP_IDX_BLOCK_WRITE, 32'h0f);
        rd(`CFP_IDX_BOOT_EEPROM_CODE, 32'hc0);
        // A second reset must latch the erased bytes afresh.
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (4) @(posedge clk_sys);
        check(outs(), 32'h1400);
        $display("test erase and reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
